/* File: rtl/rru_rotate_right_unit.sv */
// What this block does
// - Plain rotate: accumulator gets operand shifted right, bit 0 into bit 7.
// - Plain rotate writes accumulator only; memory and all flags stay unchanged.
// - Memory rotate shifts right, old carry into bit 7, result written back.
// - Rotate through carry loads carry from operand bit 0; no other flag.
// - Accumulator carry rotate does the nine-bit rotate, result into accumulator.
module rru_rotate_right_unit
(
    input  wire logic              clock_in,
    input  wire logic              srst_in,
    input  wire rru_pkg::rru_req_t req_in,
    output logic [7:0]             acc_out,
    output logic                   carry_out,
    output rru_pkg::rru_wb_t       wb_out
);
    import rru_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Helper functions

    // Shift right one place and fill the top bit from fill_bit
    function automatic logic [7:0] rru_shift_in
    (
        input logic [7:0] value,
        input logic       fill_bit
    );
        rru_shift_in = {fill_bit, value[MSB_POS:1]};
    endfunction : rru_shift_in

    // True when the request is valid and carries the given instruction
    function automatic logic rru_op_hit
    (
        input rru_req_t req,
        input rru_op_t  op
    );
        rru_op_hit = req.valid && (req.op == op);
    endfunction : rru_op_hit

    ////////////////////////////////////////////////////////////////////////////
    // Instruction decode

    logic plain_rot_hit;
    logic mem_rot_hit;
    logic acc_rot_hit;
    logic carry_rot_hit;

    // One strobe per instruction; idle cycles and the NONE code raise none
    assign plain_rot_hit = rru_op_hit(req_in, RRU_OP_ROTATE_RIGHT_INTO_ACCUMULATOR);
    assign mem_rot_hit   = rru_op_hit(req_in, RRU_OP_ROTATE_RIGHT_CARRY_IN_MEMORY);
    assign acc_rot_hit   = rru_op_hit(req_in, RRU_OP_ROTATE_RIGHT_CARRY_TO_ACCUMULATOR);
    // Both carry rotates share the nine-bit path through the flag
    assign carry_rot_hit = mem_rot_hit || acc_rot_hit;

    ////////////////////////////////////////////////////////////////////////////
    // Carry flag

    logic carry_reg;
    logic carry_next;

    // Carry moves only on a rotate through carry; the plain rotate keeps it
    always_comb
    begin
        carry_next = carry_reg;
        if (carry_rot_hit)
        begin
            carry_next = req_in.operand[LSB_POS];
        end
    end

    // Carry register
    always_ff @(posedge clock_in)
    begin
        if (srst_in)
        begin
            carry_reg <= CARRY_RST;
        end
        else
        begin
            carry_reg <= carry_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Accumulator

    logic [7:0] acc_reg;
    logic [7:0] acc_next;

    // Only the two accumulator-destination rotates load a new value
    always_comb
    begin
        acc_next = acc_reg;
        if (plain_rot_hit)
        begin
            acc_next = rru_shift_in(req_in.operand, req_in.operand[LSB_POS]);
        end
        else if (acc_rot_hit)
        begin
            acc_next = rru_shift_in(req_in.operand, carry_reg);
        end
    end

    // Accumulator register
    always_ff @(posedge clock_in)
    begin
        if (srst_in)
        begin
            acc_reg <= ACC_RST;
        end
        else
        begin
            acc_reg <= acc_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Memory write-back

    rru_wb_t wb_reg;
    rru_wb_t wb_next;

    // Only the memory rotate writes back; the data bus reads zero otherwise
    always_comb
    begin
        wb_next.write = 1'b0;
        wb_next.data  = BYTE_ZERO;
        if (mem_rot_hit)
        begin
            wb_next.write = 1'b1;
            wb_next.data  = rru_shift_in(req_in.operand, carry_reg);
        end
    end

    // Write-back register, a one-cycle pulse per memory rotate
    always_ff @(posedge clock_in)
    begin
        if (srst_in)
        begin
            wb_reg <= '0;
        end
        else
        begin
            wb_reg <= wb_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    // Every output comes straight from its state flop
    assign acc_out   = acc_reg;
    assign carry_out = carry_reg;
    assign wb_out    = wb_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    // Plain rotate: bit 0 wraps into bit 7, carry plays no part
    plain_rotate_acc_a: assert property (@(posedge clock_in) disable iff (srst_in)
        plain_rot_hit |=> acc_out == {$past(req_in.operand[LSB_POS]), $past(req_in.operand[MSB_POS:1])})
        else $error("plain rotate result wrong");

    // Plain rotate leaves memory and carry alone
    plain_rotate_side_a: assert property (@(posedge clock_in) disable iff (srst_in)
        plain_rot_hit |=> !wb_out.write && carry_out == $past(carry_out))
        else $error("plain rotate touched memory or carry");

    // Memory rotate writes the old carry into bit 7 of the byte written back
    mem_rotate_wb_a: assert property (@(posedge clock_in) disable iff (srst_in)
        mem_rot_hit |=> wb_out.write && wb_out.data == {$past(carry_out), $past(req_in.operand[MSB_POS:1])})
        else $error("memory rotate write-back wrong");

    // Memory rotate keeps the accumulator
    mem_rotate_acc_a: assert property (@(posedge clock_in) disable iff (srst_in)
        mem_rot_hit |=> acc_out == $past(acc_out))
        else $error("memory rotate changed accumulator");

    // Both carry rotates load carry from operand bit 0
    carry_from_bit0_a: assert property (@(posedge clock_in) disable iff (srst_in)
        carry_rot_hit |=> carry_out == $past(req_in.operand[LSB_POS]))
        else $error("carry not loaded from bit 0");

    // Accumulator carry rotate puts the old carry into bit 7
    acc_carry_rot_a: assert property (@(posedge clock_in) disable iff (srst_in)
        acc_rot_hit |=> acc_out == {$past(carry_out), $past(req_in.operand[MSB_POS:1])})
        else $error("carry rotate to accumulator wrong");

    // Accumulator carry rotate never writes memory
    acc_carry_nowb_a: assert property (@(posedge clock_in) disable iff (srst_in)
        acc_rot_hit |=> !wb_out.write)
        else $error("accumulator carry rotate wrote memory");

    // Idle cycles change nothing
    idle_quiet_a: assert property (@(posedge clock_in) disable iff (srst_in)
        !req_in.valid |=> !wb_out.write && $stable(acc_out) && $stable(carry_out))
        else $error("idle cycle changed state");

    // A valid request with the NONE code changes nothing either
    none_op_quiet_a: assert property (@(posedge clock_in) disable iff (srst_in)
        (req_in.valid && req_in.op == RRU_OP_NONE) |=> !wb_out.write && $stable(acc_out) && $stable(carry_out))
        else $error("empty instruction changed state");

    // The write-back strobe only ever follows a memory rotate
    mem_wb_cause_a: assert property (@(posedge clock_in) disable iff (srst_in)
        wb_out.write |-> $past(mem_rot_hit))
        else $error("write-back without memory rotate");

    // Write-back data reads zero while no write is under way
    wb_data_idle_a: assert property (@(posedge clock_in) disable iff (srst_in)
        !wb_out.write |-> wb_out.data == BYTE_ZERO)
        else $error("write-back data not zero when idle");

    // Carry moves only after a rotate through carry or a reset
    carry_cause_a: assert property (@(posedge clock_in) disable iff (srst_in)
        $changed(carry_out) |-> $past(carry_rot_hit) || $past(srst_in))
        else $error("carry changed without carry rotate");

    // Accumulator moves only after an accumulator rotate or a reset
    acc_cause_a: assert property (@(posedge clock_in) disable iff (srst_in)
        $changed(acc_out) |-> $past(plain_rot_hit) || $past(acc_rot_hit) || $past(srst_in))
        else $error("accumulator changed without accumulator rotate");

    // Reset clears accumulator, carry and write-back
    reset_values_a: assert property (@(posedge clock_in)
        srst_in |=> acc_out == ACC_RST && carry_out == CARRY_RST && !wb_out.write)
        else $error("reset values wrong");

    // Main scenarios
    cov_plain_rot_c: cover property (@(posedge clock_in) disable iff (srst_in) plain_rot_hit);
    cov_mem_pair_c:  cover property (@(posedge clock_in) disable iff (srst_in) mem_rot_hit ##1 mem_rot_hit);
    cov_mem_acc_c:   cover property (@(posedge clock_in) disable iff (srst_in) mem_rot_hit ##1 acc_rot_hit);
    cov_acc_pair_c:  cover property (@(posedge clock_in) disable iff (srst_in) acc_rot_hit ##1 acc_rot_hit);
    cov_none_op_c:   cover property (@(posedge clock_in) disable iff (srst_in) req_in.valid && req_in.op == RRU_OP_NONE);

endmodule : rru_rotate_right_unit

/* File: rtl/rru_pkg.sv */
package rru_pkg;

    // Operand width, bit positions, reset values and the zero byte
    localparam int unsigned DATA_W   = 8;
    localparam int unsigned MSB_POS  = 7;
    localparam int unsigned LSB_POS  = 0;
    localparam logic [7:0]  ACC_RST  = 8'h00;
    localparam logic        CARRY_RST = 1'b0;
    localparam logic [7:0]  BYTE_ZERO = 8'h00;

    // Instruction select
    typedef enum logic [1:0]
    {
        RRU_OP_NONE,
        RRU_OP_ROTATE_RIGHT_INTO_ACCUMULATOR,
        RRU_OP_ROTATE_RIGHT_CARRY_IN_MEMORY,
        RRU_OP_ROTATE_RIGHT_CARRY_TO_ACCUMULATOR
    } rru_op_t;

    // Request from the core: opcode strobe plus operand byte
    typedef struct packed
    {
        logic       valid;
        rru_op_t    op;
        logic [7:0] operand;
    } rru_req_t;

    // Memory write-back carrier
    typedef struct packed
    {
        logic       write;
        logic [7:0] data;
    } rru_wb_t;

endpackage : rru_pkg

/* File: dv/testbench.sv */
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import rru_pkg::*;
    logic       clock_in;
    logic       srst_in;
    rru_req_t   req_in;
    logic [7:0] acc_out;
    logic       carry_out;
    rru_wb_t    wb_out;
    int         err_total;
    int         tests_run;

    rru_rotate_right_unit rru_rotate_right_unit_i
    (
        .clock_in  (clock_in),
        .srst_in   (srst_in),
        .req_in    (req_in),
        .acc_out   (acc_out),
        .carry_out (carry_out),
        .wb_out    (wb_out)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and watchdog
    initial
    begin
        clock_in = 1'b0;
        forever #4 clock_in = ~clock_in;
    end
    initial
    begin
        repeat (500) @(posedge clock_in);
        err_total++;
        finish_test();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Compare all outputs as one snapshot
    task automatic chk(input logic [7:0] a, input logic c, input logic [8:0] w);
        tests_run++;
        if ({acc_out, carry_out, wb_out} !== {a, c, w})
        begin
            err_total++;
            $display("unexpected at %0t: acc %h carry %b wb %h", $time, acc_out, carry_out, wb_out);
        end
    endtask : chk
    // Drive one request and land just after the taking edge
    task automatic drv(input rru_op_t op, input logic [7:0] d);
        req_in = '{1'b1, op, d};
        @(posedge clock_in);
        #1;
    endtask : drv
    task automatic idle();
        req_in.valid = 1'b0;
        @(posedge clock_in);
        #1;
    endtask : idle

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_mem();
        drv(RRU_OP_ROTATE_RIGHT_CARRY_IN_MEMORY, 8'h01);
        chk(8'h00, 1'b1, {1'b1, 8'h00});
        drv(RRU_OP_ROTATE_RIGHT_CARRY_IN_MEMORY, 8'h01);
        chk(8'h00, 1'b1, {1'b1, 8'h80});
        drv(RRU_OP_ROTATE_RIGHT_CARRY_IN_MEMORY, 8'hFE);
        chk(8'h00, 1'b0, {1'b1, 8'hFF});
        idle();
        chk(8'h00, 1'b0, 9'h000);
        $display("test mem done");
    endtask : t_mem
    task automatic t_plain();
        drv(RRU_OP_ROTATE_RIGHT_CARRY_IN_MEMORY, 8'h01);
        drv(RRU_OP_ROTATE_RIGHT_INTO_ACCUMULATOR, 8'h01);
        chk(8'h80, 1'b1, 9'h000);
        drv(RRU_OP_ROTATE_RIGHT_INTO_ACCUMULATOR, 8'hA4);
        chk(8'h52, 1'b1, 9'h000);
        $display("test plain done");
    endtask : t_plain
    task automatic t_acc_carry();
        drv(RRU_OP_ROTATE_RIGHT_CARRY_TO_ACCUMULATOR, 8'h02);
        chk(8'h81, 1'b0, 9'h000);
        drv(RRU_OP_ROTATE_RIGHT_CARRY_TO_ACCUMULATOR, 8'h03);
        chk(8'h01, 1'b1, 9'h000);
        drv(RRU_OP_NONE, 8'hFF);
        chk(8'h01, 1'b1, 9'h000);
        srst_in = 1'b1;
        drv(RRU_OP_ROTATE_RIGHT_CARRY_TO_ACCUMULATOR, 8'hFF);
        chk(8'h00, 1'b0, 9'h000);
        srst_in = 1'b0;
        drv(RRU_OP_ROTATE_RIGHT_CARRY_IN_MEMORY, 8'h01);
        chk(8'h00, 1'b1, {1'b1, 8'h00});
        drv(RRU_OP_ROTATE_RIGHT_CARRY_TO_ACCUMULATOR, 8'h00);
        chk(8'h80, 1'b0, 9'h000);
        idle();
        chk(8'h80, 1'b0, 9'h000);
        $display("test acc_carry done");
    endtask : t_acc_carry

    ////////////////////////////////////////////////////////////////////////////////
    // Verdict
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : finish_test

    // Main sequence
    initial
    begin
        err_total = 0;
        tests_run = 0;
        srst_in   = 1'b1;
        req_in    = '{1'b0, RRU_OP_NONE, 8'h00};
        repeat (12) @(posedge clock_in);
        #1;
        srst_in = 1'b0;
        chk(8'h00, 1'b0, 9'h000);
        t_mem();
        t_plain();
        t_acc_carry();
        finish_test();
    end
endmodule : testbench
